// *** wdtc_core.sv ***
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module wdtc_core #(
  parameter int CNT_W = 32  // counter width
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        debug_halt,
  output logic             irq,
  output logic             nmi,
  output logic             reset_req
);

  logic             wr_go;          // write ready to apply
  logic [11:0]      wr_addr;        // captured write address
  logic [31:0]      wr_data;        // captured write data
  logic [3:0]       wr_strb;        // captured byte enables
  logic             wr_err;         // unmapped write
  wdtc_pkg::wdtc_wr_t wr;           // decoded write
  logic             halt_s;         // synchronised debug halt
  logic [CNT_W-1:0] reload_r;       // programmed reload value
  logic [CNT_W-1:0] count_r;        // live down-counter
  logic [3:0]       ctrl_r;         // enable, reset-enable, stall, nmi
  logic             locked_r;       // configuration lock
  logic             ris_r;          // raw timeout status
  logic             mask_r;         // interrupt mask, one passes
  logic             rst_r;          // reset request latch
  logic             zero_hit;       // counter reaches zero this cycle
  logic             load_now;       // reload write taking effect
  logic             tick;           // counter advances
  logic             int_on;         // interrupt allowed to processor
  logic [31:0]      ctrl_wmask;     // ctrl bits writable now

  // byte-lane merge for a 32-bit register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // address match helper used by both read and write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction : hit

  // axi write front end
  wdtc_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err)
  );

  // debug halt comes from another clock region
  wdtc_sync u_halt_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (debug_halt),
    .q       (halt_s)
  );

  // write decode
  always_comb begin
    wr.reload = wr_go && hit(wr_addr, wdtc_pkg::OFF_RELOAD);
    wr.ctrl   = wr_go && hit(wr_addr, wdtc_pkg::OFF_CTRL);
    wr.clr    = wr_go && hit(wr_addr, wdtc_pkg::OFF_RIS);
    wr.mask   = wr_go && hit(wr_addr, wdtc_pkg::OFF_MASK);
    wr.lock   = wr_go && hit(wr_addr, wdtc_pkg::OFF_LOCK);
    wr.data   = wr_data;
    wr.strb   = wr_strb;
  end
  // read-only registers accept writes silently; only unmapped space errors
  assign wr_err = !(hit(wr_addr, wdtc_pkg::OFF_RELOAD) || hit(wr_addr, wdtc_pkg::OFF_COUNT)
                 || hit(wr_addr, wdtc_pkg::OFF_CTRL) || hit(wr_addr, wdtc_pkg::OFF_RIS)
                 || hit(wr_addr, wdtc_pkg::OFF_MIS) || hit(wr_addr, wdtc_pkg::OFF_MASK)
                 || hit(wr_addr, wdtc_pkg::OFF_LOCK) || hit(wr_addr, wdtc_pkg::OFF_STAT));

  // lock register: key unlocks, anything else locks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_r <= 1'b0;
    end else if (wr.lock) begin
      locked_r <= (wr.data != wdtc_pkg::UNLOCK_KEY);
    end
  end

  // reload value; counting never touches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= wdtc_pkg::RELOAD_RST[CNT_W-1:0];
    end else if (wr.reload && !locked_r) begin
      reload_r <= CNT_W'(merge(32'(reload_r), wr.data, wr.strb));
    end
  end

  // while locked, enable and reset-enable are frozen; stall and type stay free
  always_comb begin
    ctrl_wmask = 32'h0000_000c;
    if (!locked_r) begin
      ctrl_wmask = 32'h0000_000f;
    end
  end

  // control: enable is sticky once set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= wdtc_pkg::CTRL_RST;
    end else if (wr.ctrl && wr.strb[0]) begin
      ctrl_r <= (ctrl_r & ~ctrl_wmask[3:0]) | (wr.data[3:0] & ctrl_wmask[3:0]);
      if (ctrl_r[wdtc_pkg::CTRL_EN]) begin
        ctrl_r[wdtc_pkg::CTRL_EN] <= 1'b1;
      end
    end
  end

  assign load_now = wr.reload && !locked_r && ctrl_r[wdtc_pkg::CTRL_EN];
  // stall only gates the count when the option is on
  assign tick     = ctrl_r[wdtc_pkg::CTRL_EN]
                    && !(ctrl_r[wdtc_pkg::CTRL_STALL] && halt_s);
  assign zero_hit = tick && !load_now && (count_r == '0);

  // down-counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= wdtc_pkg::RELOAD_RST[CNT_W-1:0];
    end else if (load_now) begin
      count_r <= CNT_W'(merge(32'(reload_r), wr.data, wr.strb));
    end else if (!ctrl_r[wdtc_pkg::CTRL_EN]) begin
      count_r <= reload_r;  // idle counter tracks reload
    end else if (zero_hit) begin
      count_r <= reload_r;
    end else if (tick) begin
      count_r <= count_r - 1'b1;
    end
  end

  // raw timeout status; set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ris_r <= 1'b0;
    end else if (zero_hit && ctrl_r[wdtc_pkg::CTRL_EN]) begin
      ris_r <= 1'b1;
    end else if (wr.reload && !locked_r
                 && merge(32'(reload_r), wr.data, wr.strb) == 32'h0000_0000) begin
      ris_r <= 1'b1;
    end else if (wr.clr && wr.strb[0] && wr.data[wdtc_pkg::ST_TIMEOUT]) begin
      ris_r <= 1'b0;
    end
  end

  // mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= wdtc_pkg::MASK_RST;
    end else if (wr.mask && wr.strb[0]) begin
      mask_r <= wr.data[0];
    end
  end

  // reset request on zero while first timeout still pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r <= 1'b0;
    end else if (zero_hit && ris_r && ctrl_r[wdtc_pkg::CTRL_RESEN]) begin
      rst_r <= 1'b1;
    end
  end
  assign reset_req = rst_r && ctrl_r[wdtc_pkg::CTRL_RESEN];

  // interrupt routing; enable gates both kinds
  assign int_on = ris_r && mask_r && ctrl_r[wdtc_pkg::CTRL_EN];
  assign irq    = int_on && !ctrl_r[wdtc_pkg::CTRL_NMI];
  assign nmi    = int_on && ctrl_r[wdtc_pkg::CTRL_NMI];

  // read channel: one read at a time, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= wdtc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= wdtc_pkg::RESP_OKAY;
      unique case (1'b1)
        hit(s_axi_araddr, wdtc_pkg::OFF_RELOAD): s_axi_rdata <= 32'(reload_r);
        hit(s_axi_araddr, wdtc_pkg::OFF_COUNT):  s_axi_rdata <= 32'(count_r);
        hit(s_axi_araddr, wdtc_pkg::OFF_CTRL):   s_axi_rdata <= {28'h0, ctrl_r};
        hit(s_axi_araddr, wdtc_pkg::OFF_RIS):    s_axi_rdata <= {31'h0, ris_r};
        hit(s_axi_araddr, wdtc_pkg::OFF_MIS):    s_axi_rdata <= {31'h0, int_on};
        hit(s_axi_araddr, wdtc_pkg::OFF_MASK):   s_axi_rdata <= {31'h0, mask_r};
        hit(s_axi_araddr, wdtc_pkg::OFF_LOCK):   s_axi_rdata <= {31'h0, locked_r};
        hit(s_axi_araddr, wdtc_pkg::OFF_STAT):
          s_axi_rdata <= {29'h0, ris_r, locked_r, ctrl_r[wdtc_pkg::CTRL_EN]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;  // unmapped reads zero with error
          s_axi_rresp <= wdtc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : wdtc_core

// *** wdtc_pkg.sv ***
package wdtc_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_RELOAD  = 12'h000;  // reload value
  localparam logic [11:0] OFF_COUNT   = 12'h004;  // live count, read only
  localparam logic [11:0] OFF_CTRL    = 12'h008;  // control bits
  localparam logic [11:0] OFF_RIS     = 12'h00c;  // raw status, write one to clear
  localparam logic [11:0] OFF_MIS     = 12'h010;  // masked status, read only
  localparam logic [11:0] OFF_MASK    = 12'h014;  // interrupt mask
  localparam logic [11:0] OFF_LOCK    = 12'h018;  // lock / unlock key
  localparam logic [11:0] OFF_STAT    = 12'h01c;  // running, locked, second stage

  // control field positions
  localparam int CTRL_EN      = 0;   // timer and interrupt enable, sticky
  localparam int CTRL_RESEN   = 1;   // reset on second timeout
  localparam int CTRL_STALL   = 2;   // hold count in debug halt
  localparam int CTRL_NMI     = 3;   // route timeout to nmi instead of irq; mask still applies

  // status field positions
  localparam int ST_TIMEOUT   = 0;   // first-timeout event
  localparam int ST_RUN       = 0;
  localparam int ST_LOCKED    = 1;
  localparam int ST_ARMED2    = 2;

  // unlock key; any other write to the lock register locks
  localparam logic [31:0] UNLOCK_KEY   = 32'h1acc_e551;
  localparam logic [31:0] RELOAD_RST   = 32'hffff_ffff;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic        MASK_RST     = 1'b1;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // decoded write request toward the core
  typedef struct packed {
    logic        reload;   // reload write
    logic        ctrl;     // control write
    logic        clr;      // status clear write
    logic        mask;     // mask write
    logic        lock;     // lock register write
    logic [31:0] data;
    logic [3:0]  strb;
  } wdtc_wr_t;

endpackage : wdtc_pkg

// *** wdtc_sync.sv ***
`timescale 1ns/1ns
// two flip-flop synchroniser for a level
module wdtc_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;  // first stage, read only by second

  // plain double register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : wdtc_sync

// *** wdtc_axil.sv ***
`timescale 1ns/1ns
// axi4-lite slave front end: takes aw and w in any order, one of each at a time
module wdtc_axil (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic                      wr_go,
  output logic [11:0]               wr_addr,
  output logic [31:0]               wr_data,
  output logic [3:0]                wr_strb,
  input  wire logic                 wr_err
);
  logic aw_have_r;  // address captured
  logic w_have_r;   // data captured

  // ready only while the slot is empty and no response pending
  assign awready = !aw_have_r && !bvalid;
  assign wready  = !w_have_r && !bvalid;
  assign wr_go   = aw_have_r && w_have_r && !bvalid;

  // capture address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      wr_addr   <= 12'h000;
    end else if (awvalid && awready) begin
      aw_have_r <= 1'b1;
      wr_addr   <= awaddr;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  // capture data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wr_data  <= 32'h0000_0000;
      wr_strb  <= 4'h0;
    end else if (wvalid && wready) begin
      w_have_r <= 1'b1;
      wr_data  <= wdata;
      wr_strb  <= wstrb;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  // response raised on the same edge that applies the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= wdtc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? wdtc_pkg::RESP_SLVERR : wdtc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
endmodule : wdtc_axil

// *** wdtc_sva.sv ***
`timescale 1ns/1ns
// protocol and interrupt checks on the core's ports
module wdtc_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic        nmi
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // one timeout never leaves on both lines
  irq_route_a: assert property (!(irq && nmi))
    else $error("irq and nmi high together");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not tied to rvalid");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // both halves taken together: answer after capture and apply
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // hole above the map answers zero with an error
  rd_unmap_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h020
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule : wdtc_sva

bind wdtc_core wdtc_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq), .nmi(nmi));

// *** wdtc_cpu_model.sv ***
`timescale 1ns/1ns
// processor side: debug halt source; halt changes only after an edge
module wdtc_cpu_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic halt_cmd,
  output logic      debug_halt
);
  // halt follows the bench's command one cycle late, like a core stopping
  always_ff @(posedge aclk) begin
    if (!aresetn) debug_halt <= 1'b0;
    else debug_halt <= halt_cmd;
  end
endmodule : wdtc_cpu_model

// *** wdtc_tb.sv ***
`timescale 1ns/1ns
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halt_cmd;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, c1, c2, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, irq, nmi, reset_req, debug_halt;
  int          n_mismatch, checked, i;
  int          cyc = 0;  // cycle count, driven only by the hang guard

  wdtc_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .debug_halt(debug_halt), .irq(irq), .nmi(nmi),
    .reset_req(reset_req));
  wdtc_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .halt_cmd(halt_cmd),
    .debug_halt(debug_halt));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // write: address and data offered together, each dropped when taken
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // read and compare the masked bits
  task rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d & m);
  endtask : rc

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, halt_cmd} = '0;
    {awaddr, araddr, wdata, n_mismatch, checked} = '0;
    wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values
    rc(wdtc_pkg::OFF_RELOAD, 32'hffffffff, wdtc_pkg::RELOAD_RST);
    rc(wdtc_pkg::OFF_CTRL, 32'hf, 32'h0);
    rc(wdtc_pkg::OFF_MASK, 32'h1, 32'h1);
    rc(wdtc_pkg::OFF_STAT, 32'h7, 32'h0);
    rc(12'h020, 32'hffffffff, 32'h0);
    chk("rresp", 32'h2, r);
    wr(12'h020, 32'h1);
    chk("bresp", 32'h2, r);
    // start with reset on second timeout
    wr(wdtc_pkg::OFF_RELOAD, 32'd30);
    wr(wdtc_pkg::OFF_CTRL, 32'h3);
    rc(wdtc_pkg::OFF_STAT, 32'h1, 32'h1);
    rc(wdtc_pkg::OFF_RELOAD, 32'hffffffff, 32'd30);
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
    rd(wdtc_pkg::OFF_COUNT);
    chk("reloaded", 32'h1, d != 0 && d <= 30);
    for (i = 0; i < 100 && reset_req !== 1'b1; i++) @(posedge aclk);
    chk("reset_req", 32'h1, reset_req);
    wr(wdtc_pkg::OFF_CTRL, 32'h1);
    chk("reset_req off", 32'h0, reset_req);
    wr(wdtc_pkg::OFF_RELOAD, 32'd1000);
    rd(wdtc_pkg::OFF_COUNT);
    chk("loaded now", 32'h1, d > 900 && d <= 1000);
    wr(wdtc_pkg::OFF_RIS, 32'h1);
    chk("irq clear", 32'h0, irq);
    rc(wdtc_pkg::OFF_RIS, 32'h1, 32'h0);
    // four expiries without reset enable
    wr(wdtc_pkg::OFF_RELOAD, 32'd20);
    repeat (100) @(posedge aclk);
    chk("no reset", 32'h0, reset_req);
    wr(wdtc_pkg::OFF_CTRL, 32'h9);
    chk("nmi", 32'h1, {irq, nmi});
    wr(wdtc_pkg::OFF_CTRL, 32'h1);
    chk("irq", 32'h2, {irq, nmi});
    wr(wdtc_pkg::OFF_MASK, 32'h0);
    chk("masked", 32'h0, irq);
    rc(wdtc_pkg::OFF_MIS, 32'h1, 32'h0);
    rc(wdtc_pkg::OFF_RIS, 32'h1, 32'h1);
    wr(wdtc_pkg::OFF_MASK, 32'h1);
    // zero reload fires at once
    wr(wdtc_pkg::OFF_RELOAD, 32'h0000ffff);
    wr(wdtc_pkg::OFF_RIS, 32'h1);
    rc(wdtc_pkg::OFF_RIS, 32'h1, 32'h0);
    wr(wdtc_pkg::OFF_RELOAD, 32'h0);
    rc(wdtc_pkg::OFF_RIS, 32'h1, 32'h1);
    chk("irq zero", 32'h1, irq);
    // debug stall on then off
    wr(wdtc_pkg::OFF_RELOAD, 32'h0000ffff);
    wr(wdtc_pkg::OFF_CTRL, 32'h5);
    halt_cmd <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(wdtc_pkg::OFF_COUNT);
    c1 = d;
    rd(wdtc_pkg::OFF_COUNT);
    chk("held", c1, d);
    halt_cmd <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(wdtc_pkg::OFF_COUNT);
    chk("resumed", 32'h1, d < c1);
    wr(wdtc_pkg::OFF_CTRL, 32'h1);
    halt_cmd <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(wdtc_pkg::OFF_COUNT);
    c2 = d;
    rd(wdtc_pkg::OFF_COUNT);
    chk("free run", 32'h1, d < c2);
    halt_cmd <= 1'b0;
    wr(wdtc_pkg::OFF_CTRL, 32'h0);
    rc(wdtc_pkg::OFF_CTRL, 32'h1, 32'h1);
    // lock, try, unlock, retry
    wr(wdtc_pkg::OFF_LOCK, 32'h0);
    rc(wdtc_pkg::OFF_STAT, 32'h2, 32'h2);
    wr(wdtc_pkg::OFF_RELOAD, 32'h1234);
    rc(wdtc_pkg::OFF_RELOAD, 32'hffffffff, 32'h0000ffff);
    wr(wdtc_pkg::OFF_CTRL, 32'h3);
    rc(wdtc_pkg::OFF_CTRL, 32'h2, 32'h0);
    wr(wdtc_pkg::OFF_LOCK, wdtc_pkg::UNLOCK_KEY);
    rc(wdtc_pkg::OFF_STAT, 32'h2, 32'h0);
    wr(wdtc_pkg::OFF_RELOAD, 32'h1234);
    rc(wdtc_pkg::OFF_RELOAD, 32'hffffffff, 32'h1234);
    print_verdict();
  end
endmodule : tb
